// ### sic_channel_ctrl.sv
// standard interrupt channel controller: nine edge lines, mask, polarity,
// pending, priority, overrun and latched arbitration winner
// assumes lines come from pins (synchronised here) and the cpu arbiter
// drives arb_start and ack pulses on clk_sys
`timescale 1ns/100ps
`default_nettype none

module sic_channel_ctrl #(
  parameter int NLINES = sic_pkg::sic_nlines
) (
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic [7:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  output logic      [1:0]        avs_response,
  input  wire logic [NLINES-1:0] line_in,
  input  wire logic              arb_start,
  input  wire logic              ack_valid,
  input  wire logic [3:0]        ack_code,
  output logic                   irq_req,
  output logic      [3:0]        winner_code
);

  // ==========================================================================
  // helpers
  // three-bit priority of a line: shared pair bits plus fixed parity bit
  function automatic logic [2:0] sic_line_prio(input logic [7:0] plo,
                                              input logic [1:0] phi,
                                              input int         n);
    logic [1:0] pb;
    // i0 takes its pair bits from priority_high, parity zero like any even line
    pb = (n == sic_pkg::sic_line_i0) ? phi : plo[(n/2)*2 +: 2];
    return {pb, n[0]};
  endfunction : sic_line_prio

  // ==========================================================================
  // state
  // bit 8 of mask, polarity, pending and overrun is i0, bits 7:0 are e0 to h1
  logic [NLINES-1:0] mask, next_mask;
  logic [NLINES-1:0] pol, next_pol;
  logic [NLINES-1:0] pend, next_pend;
  logic [NLINES-1:0] ovr, next_ovr;
  logic [7:0]        prio_lo, next_prio_lo;
  logic [1:0]        prio_hi, next_prio_hi;
  logic [2:0]        vec_msb, next_vec_msb;
  logic [3:0]        win, next_win;
  logic              irq, next_irq;
  logic [31:0]       rdata, next_rdata;
  logic              rdy, next_rdy;
  logic [1:0]        resp, next_resp;
  logic [NLINES-1:0] sync1, sync2, sync3;

  // ==========================================================================
  // line synchroniser: three stages, edge once stages two and three agree
  // (stage one feeds stage two only, to keep metastability contained)
  logic [NLINES-1:0] prev_stable, next_prev_stable;
  logic [NLINES-1:0] rise, fall;

  // three-stage pin capture; only stage two reads stage one
  // sync stages carry no reset: they flush within three clocks of reset
  always_ff @(posedge clk_sys) begin
    sync1 <= line_in;
    sync2 <= sync1;
    sync3 <= sync2;
  end

  // stable level only moves when stages two and three agree
  always_comb begin
    next_prev_stable = prev_stable;
    for (int n = 0; n < NLINES; n++) begin
      if (sync2[n] == sync3[n]) begin
        next_prev_stable[n] = sync3[n];
      end
    end
    rise = next_prev_stable & ~prev_stable;
    fall = ~next_prev_stable & prev_stable;
  end

  // ==========================================================================
  // bus decode
  logic       wr_hit, rd_hit;
  logic [7:0] wbyte;
  logic       wr_pol;

  // request qualifiers, taken only while the ready flop is low
  // only byte lane 0 carries register data; the other lanes are ignored
  always_comb begin
    wr_hit = avs_write && rdy == 1'b0 && avs_byteenable[0];
    rd_hit = avs_read && rdy == 1'b0;
    wbyte  = avs_writedata[7:0];
    wr_pol = wr_hit && (avs_address == sic_pkg::sic_idx_pol_low ||
                        avs_address == sic_pkg::sic_idx_pol_high);
  end

  // ==========================================================================
  // channel state: mask, polarity, pending, overrun, priority
  logic [NLINES-1:0] trig, ackd;

  // next mask, polarity, pending and overrun from writes, edges and acks
  always_comb begin
    next_mask    = mask;
    next_pol     = pol;
    next_prio_lo = prio_lo;
    next_prio_hi = prio_hi;
    next_vec_msb = vec_msb;
    next_pend    = pend;
    next_ovr     = ovr;
    trig         = '0;
    ackd         = '0;
    for (int n = 0; n < NLINES; n++) begin
      trig[n] = pol[n] ? rise[n] : fall[n];
      ackd[n] = ack_valid && (ack_code == 4'(n));
    end
    // an edge during a polarity write is dropped, as the hardware does
    // limitation: such an edge is lost, software must poll the pin if it matters
    if (wr_pol) begin
      trig = '0;
    end
    // software writes
    if (wr_hit) begin
      case (avs_address)
        sic_pkg::sic_idx_mask_high: next_mask[sic_pkg::sic_line_i0] = wbyte[0];
        sic_pkg::sic_idx_mask_low:  next_mask[7:0] = wbyte;
        sic_pkg::sic_idx_pol_high:  next_pol[sic_pkg::sic_line_i0] = wbyte[0];
        sic_pkg::sic_idx_pol_low:   next_pol[7:0] = wbyte;
        sic_pkg::sic_idx_pend_high: next_pend[sic_pkg::sic_line_i0] = wbyte[0];
        sic_pkg::sic_idx_pend_low:  next_pend[7:0] = wbyte;
        sic_pkg::sic_idx_vector:    next_vec_msb = wbyte[7:sic_pkg::sic_vec_msb_pos];
        sic_pkg::sic_idx_prio_high: next_prio_hi = wbyte[1:0];
        sic_pkg::sic_idx_prio_low:  next_prio_lo = wbyte;
        default: begin
        end
      endcase
    end
    for (int n = 0; n < NLINES; n++) begin
      if (ackd[n]) begin
        next_pend[n] = 1'b0;
        next_ovr[n] = 1'b0;
      end
      if (trig[n]) begin
        if (pend[n] && !ackd[n]) begin
          next_ovr[n] = 1'b1;
        end
        // a trigger wins over a simultaneous clear
        next_pend[n] = 1'b1;
      end
    end
  end

  // channel registers; vector msbs get a defined value though hardware leaves them open
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mask    <= '0;
      pol     <= '0;
      pend    <= '0;
      ovr     <= '0;
      prio_lo <= sic_pkg::sic_rst_prio_low;
      prio_hi <= sic_pkg::sic_rst_prio_high;
      vec_msb <= sic_pkg::sic_rst_vec_msb;
      prev_stable <= '0;
    end else begin
      mask    <= next_mask;
      pol     <= next_pol;
      pend    <= next_pend;
      ovr     <= next_ovr;
      prio_lo <= next_prio_lo;
      prio_hi <= next_prio_hi;
      vec_msb <= next_vec_msb;
      prev_stable <= next_prev_stable;
    end
  end

  // ==========================================================================
  // arbitration: lowest priority value wins, lower line index breaks a tie
  // pair members always differ, but i0 ties any even line whose pair bits equal its own
  logic [3:0] best_code;
  logic [2:0] best_prio;
  logic       any_req;

  // linear scan: cheap at nine lines and keeps tie handling predictable
  // no request leaves the no-winner code, which the cpu reads as idle
  always_comb begin
    best_code = sic_pkg::sic_no_winner;
    best_prio = sic_pkg::sic_prio_lowest;
    any_req   = 1'b0;
    for (int n = 0; n < NLINES; n++) begin
      if (mask[n] && pend[n]) begin
        if (!any_req || sic_line_prio(prio_lo, prio_hi, n) < best_prio) begin
          best_prio = sic_line_prio(prio_lo, prio_hi, n);
          best_code = 4'(n);
        end
        any_req = 1'b1;
      end
    end
    next_irq = any_req;
    next_win = win;
    // latch winner at start only
    // held through the cycle so a later, higher request waits for the next round
    if (arb_start) begin
      next_win = best_code;
    end
  end

  // winner and request registers; winner shows the no-winner code after reset
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      win <= sic_pkg::sic_rst_winner;
      irq <= 1'b0;
    end else begin
      win <= next_win;
      irq <= next_irq;
    end
  end

  // ==========================================================================
  // read path: one wait cycle, then data with waitrequest low
  // ready rises for a single cycle and then drops, so a request still held
  // is taken again two cycles later
  always_comb begin
    next_rdata = rdata;
    next_rdy   = 1'b0;
    next_resp  = 2'h0;
    if ((avs_read || avs_write) && !rdy) begin
      next_rdy = 1'b1;
    end
    if (rd_hit) begin
      // reserved bits always read zero
      next_rdata = '0;
      case (avs_address)
        sic_pkg::sic_idx_mask_high: next_rdata[0] = mask[sic_pkg::sic_line_i0];
        sic_pkg::sic_idx_mask_low:  next_rdata[7:0] = mask[7:0];
        sic_pkg::sic_idx_pol_high:  next_rdata[0] = pol[sic_pkg::sic_line_i0];
        sic_pkg::sic_idx_pol_low:   next_rdata[7:0] = pol[7:0];
        sic_pkg::sic_idx_pend_high: next_rdata[0] = pend[sic_pkg::sic_line_i0];
        sic_pkg::sic_idx_pend_low:  next_rdata[7:0] = pend[7:0];
        sic_pkg::sic_idx_vector:    next_rdata[7:0] = {vec_msb, win, 1'b0};
        sic_pkg::sic_idx_prio_high: next_rdata[1:0] = prio_hi;
        sic_pkg::sic_idx_prio_low:  next_rdata[7:0] = prio_lo;
        sic_pkg::sic_idx_ovr_high:  next_rdata[0] = ovr[sic_pkg::sic_line_i0];
        sic_pkg::sic_idx_ovr_low:   next_rdata[7:0] = ovr[7:0];
        // unmapped index reads zero with a slave-error response
        default: next_resp = 2'h2;
      endcase
    end else if (wr_hit || (avs_write && !rdy)) begin
      if (avs_address < sic_pkg::sic_idx_mask_high) begin
        next_resp = 2'h2;
      end
    end
  end

  // bus answer registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdata <= '0;
      rdy   <= 1'b0;
      resp  <= 2'h0;
    end else begin
      rdata <= next_rdata;
      rdy   <= next_rdy;
      resp  <= next_resp;
    end
  end

  // outputs straight from flip-flops
  // waitrequest is the inverse of the ready flop, so it idles high
  assign avs_readdata    = rdata;
  assign avs_waitrequest = ~rdy;
  assign avs_response    = resp;
  assign irq_req         = irq;
  assign winner_code     = win;

endmodule : sic_channel_ctrl

`default_nettype wire

// ### sic_pkg.sv
// package for the standard interrupt channel controller
// assumes an avalon-mm slave with byte-wide registers at word addresses
package sic_pkg;
  // ==========================================================================
  // register offsets (printed offsets are not all multiples of four, so
  // each is a register index and the byte address is four times it)
  localparam logic [7:0] sic_idx_mask_high   = 8'hf5;
  localparam logic [7:0] sic_idx_mask_low    = 8'hf6;
  localparam logic [7:0] sic_idx_pol_high    = 8'hf7;
  localparam logic [7:0] sic_idx_pol_low     = 8'hf8;
  localparam logic [7:0] sic_idx_pend_high   = 8'hf9;
  localparam logic [7:0] sic_idx_pend_low    = 8'hfa;
  localparam logic [7:0] sic_idx_vector      = 8'hfb;
  localparam logic [7:0] sic_idx_prio_high   = 8'hfc;
  localparam logic [7:0] sic_idx_prio_low    = 8'hfd;
  localparam logic [7:0] sic_idx_ovr_high    = 8'hfe;
  localparam logic [7:0] sic_idx_ovr_low     = 8'hff;
  // ==========================================================================
  // reset values
  localparam logic [7:0] sic_rst_zero        = 8'h00;
  localparam logic [7:0] sic_rst_prio_low    = 8'hff;
  localparam logic [1:0] sic_rst_prio_high   = 2'h3;
  localparam logic [2:0] sic_rst_vec_msb     = 3'h0;
  localparam logic [3:0] sic_rst_winner      = 4'hf;
  // ==========================================================================
  // channel layout: 0..7 are e0..h1, 8 is i0
  localparam int         sic_nlines          = 9;
  localparam int         sic_line_i0         = 8;
  localparam logic [2:0] sic_prio_lowest     = 3'h7;
  localparam logic [3:0] sic_no_winner       = 4'hf;
  // vector register fields
  localparam int         sic_vec_msb_pos     = 5;
  localparam int         sic_win_pos         = 1;
endpackage : sic_pkg

// ### sic_asserts.sv
// port checker for the standard interrupt channel controller
// assumes one clock domain with a synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module sic_asserts #(
  parameter int NLINES = 9
) (
  input wire logic              clk_sys,
  input wire logic              reset,
  input wire logic [7:0]        avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_writedata,
  input wire logic [3:0]        avs_byteenable,
  input wire logic [31:0]       avs_readdata,
  input wire logic              avs_waitrequest,
  input wire logic [1:0]        avs_response,
  input wire logic [NLINES-1:0] line_in,
  input wire logic              arb_start,
  input wire logic              ack_valid,
  input wire logic [3:0]        ack_code,
  input wire logic              irq_req,
  input wire logic [3:0]        winner_code
);
  // ==========================================================================
  // bus and arbitration properties
  default clocking dcb @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_reset_idle: assert property ($fell(reset) |-> avs_waitrequest && !irq_req
    && winner_code == sic_pkg::sic_no_winner) else $error("outputs not idle after reset");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  a_answer_next: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
    else $error("answer not one cycle after request");
  a_upper_zero: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("readdata upper bits not zero");
  a_unmapped_error: assert property (avs_read && !avs_waitrequest
    && avs_address < sic_pkg::sic_idx_mask_high |-> avs_response == 2'h2
    && avs_readdata[7:0] == 8'h00) else $error("unmapped read not refused");
  a_mapped_okay: assert property (!avs_waitrequest
    && avs_address >= sic_pkg::sic_idx_mask_high |-> avs_response == 2'h0)
    else $error("mapped access refused");
  a_winner_hold: assert property (!arb_start |=> $stable(winner_code))
    else $error("winner code moved without arbitration start");
  a_winner_range: assert property (arb_start |=> winner_code <= 4'h8
    || winner_code == 4'hf) else $error("winner code out of range");
  a_vector_bit0: assert property (avs_read && !avs_waitrequest
    && avs_address == sic_pkg::sic_idx_vector |-> avs_readdata[0] == 1'b0)
    else $error("vector bit 0 not zero");
  // main scenarios reached
  c_arb: cover property (arb_start);
  c_ack: cover property (ack_valid);
  c_err: cover property (!avs_waitrequest && avs_response == 2'h2);
endmodule : sic_asserts
bind sic_channel_ctrl sic_asserts #(.NLINES(NLINES)) u_asserts (
  .clk_sys(clk_sys), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .avs_response(avs_response), .line_in(line_in), .arb_start(arb_start),
  .ack_valid(ack_valid), .ack_code(ack_code), .irq_req(irq_req), .winner_code(winner_code));
`default_nettype wire

// ### sic_arb_model.sv
// cpu-side arbitration model: starts arbitration on a request, acks the winner
// assumes winner_code stands from the cycle after arb_start
`timescale 1ns/100ps
`default_nettype none
module sic_arb_model (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       irq_req,
  input  wire logic [3:0] winner_code,
  input  wire logic [3:0] gap,
  output logic            arb_start,
  output logic            ack_valid,
  output logic [3:0]      ack_code
);
  initial begin
    arb_start = 1'b0;
    ack_valid = 1'b0;
    ack_code  = 4'h0;
  end
  // one arbitration per request; gap models a slow core, code is scrambled when idle
  always begin
    @(posedge clk_sys);
    if (!reset && irq_req === 1'b1) begin
      repeat (gap) @(posedge clk_sys);
      arb_start <= 1'b1;
      @(posedge clk_sys);
      arb_start <= 1'b0;
      repeat (2) @(posedge clk_sys);
      ack_valid <= 1'b1;
      ack_code  <= winner_code;
      @(posedge clk_sys);
      ack_valid <= 1'b0;
      ack_code  <= ~ack_code;
      repeat (3) @(posedge clk_sys);
    end
  end
endmodule : sic_arb_model
`default_nettype wire

// ### testbench.sv
// self-checking bench for the standard interrupt channel controller
// assumes the arbiter model acknowledges every request the block raises
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'h1;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  avs_response;
  logic [8:0]  line_in = 9'h000;
  logic        arb_start, ack_valid, irq_req;
  logic [3:0]  ack_code, winner_code;
  logic [3:0]  gap = 4'h0;
  logic [9:0]  rq [$];
  logic [3:0]  wq [$];
  int          mismatches = 0;
  int          cmp_count = 0;
  logic [7:0]  r;
  logic [7:0]  rv [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1e, 8'h03, 8'hff,
                           8'h00, 8'h00};
  always #25 clk_sys = ~clk_sys;
  sic_channel_ctrl uut (.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .line_in(line_in), .arb_start(arb_start),
    .ack_valid(ack_valid), .ack_code(ack_code), .irq_req(irq_req), .winner_code(winner_code));
  sic_arb_model u_arb (.clk_sys(clk_sys), .reset(reset), .irq_req(irq_req), .gap(gap),
    .winner_code(winner_code), .arb_start(arb_start), .ack_valid(ack_valid), .ack_code(ack_code));
  // ==========================================================================
  // helpers
  task automatic check(input string nm, input logic [9:0] e, input logic [9:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  // one avalon access; the request stands until waitrequest is seen low
  task automatic bus(input logic is_rd, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_read      <= is_rd;
    avs_write     <= ~is_rd;
    avs_address   <= a;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (n >= 100) begin
      mismatches++;
      $display("[FAIL] waitrequest expected 0 seen %b", avs_waitrequest);
    end
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [9:0] e);
    rq.push_back(e);
    bus(1'b1, a, 8'h00);
  endtask : rd
  // a pin edge needs four edges to reach pending, so eight is settled
  task automatic pin(input int b, input logic v);
    line_in[b] <= v;
    repeat (8) @(posedge clk_sys);
  endtask : pin
  // monitor: oldest note against each read answer and each acknowledged winner
  always @(posedge clk_sys) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      if (rq.size() == 0) begin
        mismatches++;
        $display("[FAIL] read note expected 1 seen 0");
      end else check("readdata", rq.pop_front(), {avs_response, avs_readdata[7:0]});
    end
    if (ack_valid === 1'b1) begin
      if (wq.size() == 0) begin
        mismatches++;
        $display("[FAIL] winner note expected 1 seen 0");
      end else check("winner_code", {6'h0, wq.pop_front()}, {6'h0, winner_code});
    end
  end
  // watchdog sized well beyond the run of some two hundred and fifty cycles
  initial begin
    #1000000;
    mismatches++;
    $display("[FAIL] watchdog expected done seen timeout");
    print_verdict();
  end
  // ==========================================================================
  // main sequence
  initial begin
    void'($urandom(32'h566e));
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    for (int i = 0; i < 11; i++) rd(8'(245 + i), {2'h0, rv[i]});
    rd(8'h10, 10'h200);
    r = 8'($urandom());
    bus(1'b0, 8'hfd, r);
    rd(8'hfd, {2'h0, r});
    avs_byteenable <= 4'h0;
    bus(1'b0, 8'hfd, ~r);
    avs_byteenable <= 4'h1;
    rd(8'hfd, {2'h0, r});
    bus(1'b0, 8'hfb, 8'ha5);
    rd(8'hfb, 10'h0be);
    bus(1'b0, 8'hf8, 8'hff);
    pin(2, 1'b1);
    rd(8'hfa, 10'h004);
    check("irq_req", 10'h000, {9'h0, irq_req});
    pin(2, 1'b0);
    pin(2, 1'b1);
    bus(1'b0, 8'hff, 8'h00);
    rd(8'hff, 10'h004);
    pin(8, 1'b1);
    pin(8, 1'b0);
    rd(8'hf9, 10'h001);
    pin(8, 1'b1);
    pin(8, 1'b0);
    rd(8'hfe, 10'h001);
    // i0 at level 0, e0 2, e1 3, f0 4, so acks come as 8, 0, 1, 2
    gap <= 4'($urandom_range(0, 5));
    wq = '{4'h8, 4'h0, 4'h1, 4'h2};
    bus(1'b0, 8'hfc, 8'h00);
    bus(1'b0, 8'hfd, 8'hf9);
    bus(1'b0, 8'hfa, 8'h07);
    bus(1'b0, 8'hf5, 8'h01);
    @(posedge clk_sys);
    check("irq_req", 10'h001, {9'h0, irq_req});
    bus(1'b0, 8'hf6, 8'hff);
    for (int n = 0; n < 400 && wq.size() != 0; n++) @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
    check("winners left", 10'h000, 10'(wq.size()));
    rd(8'hfa, 10'h000);
    rd(8'hf9, 10'h000);
    rd(8'hff, 10'h000);
    rd(8'hfe, 10'h000);
    bus(1'b0, 8'hf5, 8'h00);
    bus(1'b0, 8'hf7, 8'h01);
    rd(8'hf7, 10'h001);
    pin(8, 1'b1);
    rd(8'hf9, 10'h001);
    check("irq_req", 10'h000, {9'h0, irq_req});
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
